// >>> io_port_alt_function_steering_tb_top.sv
// Self-checking bench for the port registers and pin steering
`timescale 1ns/1ps
`define CHK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin errTotal++; \
    $display("Error %0t: got %0h expected %0h", $time, got, exp); end end
module io_port_alt_function_steering_tb_top;
    import iom_pkg::*;
    typedef struct packed {logic [7:0] wa, wd, ra, ex; logic [1:0] wr;} iom_row_t;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, rxdtIn, txckIn, ssIn, t1gIn, ccpIn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, resp;
    logic [5:0]  pinIn, pinOut, pinOe, extLvl;
    logic [4:0]  perOut, perEn;
    int          errTotal, checked, pa;
    wire  [6:0]  inVec = {t1gIn, ssIn, ccpIn, 2'b00, txckIn, rxdtIn};
    // Function order: receive, transmit, data out, pwm, capture, slave select, gate
    int sb[7] = '{SEL_RXDT, SEL_TXCK, SEL_SDO, SEL_PWMB, SEL_CCP, SEL_SS, SEL_T1G};
    int p0[7] = '{RXDT_PIN0, TXCK_PIN0, SDO_PIN0, PWMB_PIN0, CCP_PIN0, SS_PIN0, T1G_PIN0};
    int p1[7] = '{RXDT_PIN1, TXCK_PIN1, SDO_PIN1, PWMB_PIN1, CCP_PIN1, SS_PIN1, T1G_PIN1};
    // Write then read back; the last rows prove a select write spares the direction bits
    iom_row_t rows[10] = '{
        '{OFF_ALTSEL, 8'hff, OFF_ALTSEL, 8'hef, RESP_OKAY}, '{OFF_DIR, 8'h00, OFF_DIR, 8'h08, RESP_OKAY},
        '{OFF_ALTSEL, 8'h00, OFF_DIR, 8'h08, RESP_OKAY}, '{OFF_PINLVL, 8'h2a, OFF_LATCH, 8'h2a, RESP_OKAY},
        '{OFF_LATCH, 8'h15, OFF_LATCH, 8'h15, RESP_OKAY}, '{OFF_ANALOG, 8'h3f, OFF_ANALOG, 8'h3f, RESP_OKAY},
        '{8'h14, 8'h55, 8'h14, 8'h00, RESP_SLVERR}, '{OFF_ANALOG, 8'h00, OFF_ANALOG, 8'h00, RESP_OKAY},
        '{OFF_DIR, 8'h3f, OFF_DIR, 8'h3f, RESP_OKAY}, '{OFF_ALTSEL, 8'hff, OFF_DIR, 8'h3f, RESP_OKAY}};

    iom_port_top u_iom_port_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .rxdtOut(perOut[0]), .rxdtOe(perEn[0]), .txckOut(perOut[1]), .txckOe(perEn[1]),
        .sdoOut(perOut[2]), .sdoEn(perEn[2]), .pwmbOut(perOut[3]), .pwmbEn(perEn[3]),
        .ccpOut(perOut[4]), .ccpEn(perEn[4]), .rxdtIn(rxdtIn), .txckIn(txckIn), .ssIn(ssIn),
        .t1gIn(t1gIn), .ccpIn(ccpIn));
    iom_pad_model u_iom_pad_model (.pinOut(pinOut), .pinOe(pinOe), .extLvl(extLvl), .pinIn(pinIn));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic completeRun;
        if (errTotal == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : completeRun

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 40);
        resp = bresp;
        bready <= 1'b0;
        if (!bvalid) begin errTotal++; completeRun(); end
    endtask : wr

    // Bus read: ready held until the answer is sampled
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 40);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (!rvalid) begin errTotal++; completeRun(); end
        `CHK_EQ(rd, {24'h0, e})
    endtask : rdx

    initial begin
        rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; extLvl = 6'h00; perOut = 5'h00; perEn = 5'h00;
        errTotal = 0; checked = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // Register rows
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            `CHK_EQ(resp, rows[i].wr)
            rdx(rows[i].ra, rows[i].ex);
            `CHK_EQ(resp, rows[i].wr)
        end
        // Pin levels versus latch, analog masking
        wr(OFF_LATCH, 8'h2a);
        extLvl <= 6'h25;
        repeat (3) @(posedge clk);
        rdx(OFF_PINLVL, 8'h25);
        rdx(OFF_LATCH, 8'h2a);
        wr(OFF_ANALOG, 8'h05);
        rdx(OFF_PINLVL, 8'h20);
        wr(OFF_ANALOG, 8'h00);
        // Each steered function on both candidates, inputs first, then drive
        for (int k = 0; k < 7; k++) begin
            for (int s = 0; s < 2; s++) begin
                pa = s ? p1[k] : p0[k];
                wr(OFF_ALTSEL, 8'(s << sb[k]));
                extLvl <= 6'(1 << p0[k]);
                repeat (4) @(posedge clk);
                if (k == 0 || k == 1 || k > 3) `CHK_EQ(inVec[k], 1'(pa == p0[k]))
                if (k < 5) begin
                    perEn <= 5'(1 << k);
                    perOut <= s ? 5'h00 : 5'h1f;
                    repeat (2) @(posedge clk);
                    `CHK_EQ(pinOe, 6'(1 << pa))
                    `CHK_EQ(pinOut[pa], 1'(s == 0))
                    perEn <= 5'h00;
                end
            end
        end
        // pwm moves pins one registered cycle after the select write lands
        perEn <= 5'h08;
        wr(OFF_ALTSEL, 8'h02);
        `CHK_EQ(pinOe, 6'h01)
        @(posedge clk);
        `CHK_EQ(pinOe, 6'h10)
        perEn <= 5'h00;
        // Drivers follow the latch, the input-only pin stays undriven
        wr(OFF_DIR, 8'h00);
        repeat (2) @(posedge clk);
        `CHK_EQ(pinOe, 6'h37)
        `CHK_EQ(pinOut & pinOe, 6'h22)
        // Second reset in mid-run returns every register to its reset value
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdx(OFF_DIR, 8'h08);
        rdx(OFF_LATCH, 8'h00);
        rdx(OFF_ANALOG, 8'h00);
        rdx(OFF_ALTSEL, 8'h00);
        completeRun();
    end
endmodule : io_port_alt_function_steering_tb_top

// >>> iom_pad_model.sv
// Pad model: pins show the block's drive where enabled, else the board level
`timescale 1ns/1ps
module iom_pad_model (
    // Block side
    input  wire logic [iom_pkg::PIN_N-1:0] pinOut,
    input  wire logic [iom_pkg::PIN_N-1:0] pinOe,
    // Board side
    input  wire logic [iom_pkg::PIN_N-1:0] extLvl,
    output logic [iom_pkg::PIN_N-1:0]      pinIn
);
    import iom_pkg::*;
    // A released pin falls back to the board level, so stale drive never lingers
    assign pinIn = (pinOut & pinOe) | (extLvl & ~pinOe);
endmodule : iom_pad_model

// >>> iom_pkg.sv
// Shared constants for the port and alternate-pin steering block
package iom_pkg;
    // Bus shape
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          PIN_N         = 6;
    // Register byte offsets
    localparam logic [7:0]  OFF_DIR       = 8'h00;
    localparam logic [7:0]  OFF_PINLVL    = 8'h04;
    localparam logic [7:0]  OFF_LATCH     = 8'h08;
    localparam logic [7:0]  OFF_ANALOG    = 8'h0c;
    localparam logic [7:0]  OFF_ALTSEL    = 8'h10;
    // Reset values
    localparam logic [5:0]  DIR_RST       = 6'h00;
    localparam logic [5:0]  LATCH_RST     = 6'h00;
    localparam logic [5:0]  ANALOG_RST    = 6'h00;
    localparam logic [7:0]  ALTSEL_RST    = 8'h00;
    // Selection register field positions
    localparam int          SEL_RXDT      = 7;
    localparam int          SEL_SDO       = 6;
    localparam int          SEL_SS        = 5;
    localparam int          SEL_UNUSED    = 4;
    localparam int          SEL_T1G       = 3;
    localparam int          SEL_TXCK      = 2;
    localparam int          SEL_PWMB      = 1;
    localparam int          SEL_CCP       = 0;
    // Writable bits of the selection register
    localparam logic [7:0]  ALTSEL_MASK   = 8'hef;
    // Input-only pin
    localparam int          IN_ONLY_PIN   = 3;
    // Candidate pins per function: choice 0 and choice 1
    localparam int          RXDT_PIN0     = 1;
    localparam int          RXDT_PIN1     = 5;
    localparam int          SDO_PIN0      = 0;
    localparam int          SDO_PIN1      = 4;
    localparam int          SS_PIN0       = 3;
    localparam int          SS_PIN1       = 0;
    localparam int          T1G_PIN0      = 4;
    localparam int          T1G_PIN1      = 3;
    localparam int          TXCK_PIN0     = 0;
    localparam int          TXCK_PIN1     = 4;
    localparam int          PWMB_PIN0     = 0;
    localparam int          PWMB_PIN1     = 4;
    localparam int          CCP_PIN0      = 2;
    localparam int          CCP_PIN1      = 5;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : iom_pkg

// >>> iom_port_top.sv
// Port registers, pin drivers and AXI4-Lite slave with alternate-pin steering
// Behaviour
// - Each steered function goes to one of two pins chosen by the select register.
// - Steered: receive/data, transmit/clock, data out, slave select, gate, PWM B, capture A.
// - Writing the select register never alters the direction register.
// - Peripheral value and drive overrides reach only the chosen pin.
// - The unchosen pin stays under ordinary port control.
// - Select bits: 7 rx, 6 data out, 5 slave select, 4 none, 3 gate, 2 tx, 1 pwm, 0 ccp.
// - The port has direction, pin-level and output-latch registers.
// - Writing the latch register acts exactly like writing the pin-level register.
// - Latch reads give stored values; pin-level reads give sensed pin levels.
// - Analog-select bits disable the digital input path of their pins.
// - An enabled peripheral takes its pin away from general-purpose use.
// - Direction one makes an input; zero drives the latch value onto the pin.
// - Digital reads of analog-selected pins return zero.
// - The input-only pin reads its direction bit as one always.
// - Pin-level writes are read-modify-write, result stored into the latch.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iom_port_top (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // AXI4-Lite write address
    input  wire logic [iom_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [iom_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [iom_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // AXI4-Lite read data
    output logic [iom_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Package pins
    input  wire logic [iom_pkg::PIN_N-1:0]  pinIn,
    output logic [iom_pkg::PIN_N-1:0]       pinOut,
    output logic [iom_pkg::PIN_N-1:0]       pinOe,
    // Peripheral outputs with drive requests
    input  wire logic                       rxdtOut,
    input  wire logic                       rxdtOe,
    input  wire logic                       txckOut,
    input  wire logic                       txckOe,
    input  wire logic                       sdoOut,
    input  wire logic                       sdoEn,
    input  wire logic                       pwmbOut,
    input  wire logic                       pwmbEn,
    input  wire logic                       ccpOut,
    input  wire logic                       ccpEn,
    // Routed peripheral inputs
    output logic                            rxdtIn,
    output logic                            txckIn,
    output logic                            ssIn,
    output logic                            t1gIn,
    output logic                            ccpIn
);
    import iom_pkg::*;

    logic [PIN_N-1:0]  dir_r;
    logic [PIN_N-1:0]  latch_r;
    logic [PIN_N-1:0]  analog_r;
    logic [7:0]        altSel_r;
    // Pin synchroniser stages
    logic [PIN_N-1:0]  pinMeta_r;
    logic [PIN_N-1:0]  pinSync_r;
    // Write channel holding state
    logic              awReady_r;
    logic              wReady_r;
    logic              awHave_r;
    logic              wHave_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic [7:0]        wByte_r;
    logic              wLane0_r;
    logic              bValid_r;
    logic [1:0]        bResp_r;
    // Read channel state
    logic              arReady_r;
    logic              rValid_r;
    logic [DATA_W-1:0] rData_r;
    logic [1:0]        rResp_r;
    // Registered pin drivers and peripheral inputs
    logic [PIN_N-1:0]  pinOut_r;
    logic [PIN_N-1:0]  pinOe_r;
    logic              rxdtIn_r;
    logic              txckIn_r;
    logic              ssIn_r;
    logic              t1gIn_r;
    logic              ccpIn_r;
    // Combinational helpers
    logic [PIN_N-1:0]  pinDigital;
    logic [PIN_N-1:0]  dirView;
    logic              wrFire;
    logic              wrLatch;

    iom_steer_if st ();

    // Decode of a mapped register offset
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_DIR) || (a == OFF_PINLVL) || (a == OFF_LATCH) ||
               (a == OFF_ANALOG) || (a == OFF_ALTSEL);
    endfunction : isMapped

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinMeta_r <= '0;
            pinSync_r <= '0;
        end else begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
        end
    end

    assign pinDigital = pinSync_r & ~analog_r;

    always_comb begin
        dirView              = dir_r;
        dirView[IN_ONLY_PIN] = 1'b1;
    end

    // Write performed once address and data are both held and no response is pending
    assign wrFire  = awHave_r && wHave_r && !bValid_r;
    assign wrLatch = wrFire && wLane0_r && ((awAddr_r == OFF_PINLVL) || (awAddr_r == OFF_LATCH));

    // Write address channel: taken independently of write data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awReady_r <= 1'b0;
            awHave_r  <= 1'b0;
            awAddr_r  <= '0;
        end else if (s_axi_awvalid && awReady_r) begin
            awReady_r <= 1'b0;
            awHave_r  <= 1'b1;
            awAddr_r  <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
        end else if (wrFire) begin
            awHave_r  <= 1'b0;
        end else if (!awHave_r && !bValid_r) begin
            awReady_r <= 1'b1;
        end
    end

    // Write data channel: only byte lane 0 carries register bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wReady_r <= 1'b0;
            wHave_r  <= 1'b0;
            wByte_r  <= '0;
            wLane0_r <= 1'b0;
        end else if (s_axi_wvalid && wReady_r) begin
            wReady_r <= 1'b0;
            wHave_r  <= 1'b1;
            wByte_r  <= s_axi_wdata[7:0];
            wLane0_r <= s_axi_wstrb[0];
        end else if (wrFire) begin
            wHave_r  <= 1'b0;
        end else if (!wHave_r && !bValid_r) begin
            wReady_r <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bValid_r <= 1'b0;
            bResp_r  <= RESP_OKAY;
        end else if (wrFire) begin
            bValid_r <= 1'b1;
            bResp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
        end
    end

    // Direction register; the select register has no path in here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_r <= DIR_RST;
        end else if (wrFire && wLane0_r && awAddr_r == OFF_DIR) begin
            dir_r <= wByte_r[PIN_N-1:0];
        end
    end

    // Output latch: whole byte replaces the pin image, so the read half of the cycle is moot
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_r <= LATCH_RST;
        end else if (wrLatch) begin
            latch_r <= wByte_r[PIN_N-1:0];
        end
    end

    // Analog-select register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analog_r <= ANALOG_RST;
        end else if (wrFire && wLane0_r && awAddr_r == OFF_ANALOG) begin
            analog_r <= wByte_r[PIN_N-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            altSel_r <= ALTSEL_RST;
        end else if (wrFire && wLane0_r && awAddr_r == OFF_ALTSEL) begin
            altSel_r <= wByte_r & ALTSEL_MASK;
        end
    end

    // Read channel: data registered at the address handshake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            arReady_r <= 1'b0;
            rValid_r  <= 1'b0;
            rData_r   <= '0;
            rResp_r   <= RESP_OKAY;
        end else if (s_axi_arvalid && arReady_r) begin
            arReady_r <= 1'b0;
            rValid_r  <= 1'b1;
            rResp_r   <= isMapped({s_axi_araddr[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
            unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFF_DIR:    rData_r <= {{(DATA_W-PIN_N){1'b0}}, dirView};
                OFF_PINLVL: rData_r <= {{(DATA_W-PIN_N){1'b0}}, pinDigital};
                OFF_LATCH:  rData_r <= {{(DATA_W-PIN_N){1'b0}}, latch_r};
                OFF_ANALOG: rData_r <= {{(DATA_W-PIN_N){1'b0}}, analog_r};
                OFF_ALTSEL: rData_r <= {{(DATA_W-8){1'b0}}, altSel_r};
                default:    rData_r <= '0;
            endcase
        end else if (rValid_r && s_axi_rready) begin
            rValid_r  <= 1'b0;
        end else if (!rValid_r) begin
            arReady_r <= 1'b1;
        end
    end

    // Carrier toward the steering multiplexer
    assign st.altSel     = altSel_r;
    assign st.pinDigital = pinDigital;
    assign st.rxdtOut    = rxdtOut;
    assign st.rxdtOe     = rxdtOe;
    assign st.txckOut    = txckOut;
    assign st.txckOe     = txckOe;
    assign st.sdoOut     = sdoOut;
    assign st.sdoEn      = sdoEn;
    assign st.pwmbOut    = pwmbOut;
    assign st.pwmbEn     = pwmbEn;
    assign st.ccpOut     = ccpOut;
    assign st.ccpEn      = ccpEn;

    iom_steer_mux u_mux (
        .st (st.mux)
    );

    // Pin drivers: peripheral override first, then ordinary port control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinOut_r <= '0;
            pinOe_r  <= '0;
        end else begin
            for (int p = 0; p < PIN_N; p++) begin
                if (p == IN_ONLY_PIN) begin
                    // Input-only pin has no driver at all
                    pinOut_r[p] <= 1'b0;
                    pinOe_r[p]  <= 1'b0;
                end else if (st.ovrEn[p]) begin
                    pinOut_r[p] <= st.ovrVal[p];
                    pinOe_r[p]  <= 1'b1;
                end else begin
                    pinOut_r[p] <= latch_r[p];
                    pinOe_r[p]  <= !dir_r[p];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxdtIn_r <= 1'b0;
            txckIn_r <= 1'b0;
            ssIn_r   <= 1'b0;
            t1gIn_r  <= 1'b0;
            ccpIn_r  <= 1'b0;
        end else begin
            rxdtIn_r <= st.rxdtIn;
            txckIn_r <= st.txckIn;
            ssIn_r   <= st.ssIn;
            t1gIn_r  <= st.t1gIn;
            ccpIn_r  <= st.ccpIn;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awReady_r;
    assign s_axi_wready  = wReady_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign pinOut        = pinOut_r;
    assign pinOe         = pinOe_r;
    assign rxdtIn        = rxdtIn_r;
    assign txckIn        = txckIn_r;
    assign ssIn          = ssIn_r;
    assign t1gIn         = t1gIn_r;
    assign ccpIn         = ccpIn_r;
endmodule : iom_port_top

// >>> iom_port_top_monitor.sv
// Checker for bus handshakes and pin steering of the port block
`timescale 1ns/1ps
module iom_port_monitor (
    // Clock, reset and bus handshakes
    input wire logic                      clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic                      s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic                      s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]                s_axi_bresp, s_axi_rresp,
    // Pins and peripheral drive requests
    input wire logic [iom_pkg::PIN_N-1:0] pinOut, pinOe,
    input wire logic                      txckOut, txckOe, sdoEn, ccpEn
);
    import iom_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_in_only; !pinOe[IN_ONLY_PIN]; endproperty
    a_in_only: assert property (p_in_only) else $error("input-only pin driven");
    property p_txck; txckOe |=> (pinOe[TXCK_PIN0] && pinOut[TXCK_PIN0] == $past(txckOut))
        || (pinOe[TXCK_PIN1] && pinOut[TXCK_PIN1] == $past(txckOut)); endproperty
    a_txck: assert property (p_txck) else $error("transmit clock not on its pin");
    property p_sdo; sdoEn |=> pinOe[SDO_PIN0] || pinOe[SDO_PIN1]; endproperty
    a_sdo: assert property (p_sdo) else $error("data out pin not driven");
    property p_ccp; ccpEn |=> pinOe[CCP_PIN0] || pinOe[CCP_PIN1]; endproperty
    a_ccp: assert property (p_ccp) else $error("capture pin not driven");
    property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_one_rd; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_one_rd: assert property (p_one_rd) else $error("read taken while answering");
endmodule : iom_port_monitor
bind iom_port_top iom_port_monitor u_iom_port_monitor (.clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
    .pinOut(pinOut), .pinOe(pinOe), .txckOut(txckOut), .txckOe(txckOe), .sdoEn(sdoEn), .ccpEn(ccpEn));

// >>> iom_steer_if.sv
// Carrier between the register/pin top and the steering multiplexer
`timescale 1ns/1ps
interface iom_steer_if;
    import iom_pkg::*;
    logic [7:0]       altSel;      // Registered steering selection
    logic [PIN_N-1:0] pinDigital;  // Synchronised pin levels, analog pins forced low
    // Peripheral outputs with their drive requests
    logic             rxdtOut;
    logic             rxdtOe;
    logic             txckOut;
    logic             txckOe;
    logic             sdoOut;
    logic             sdoEn;
    logic             pwmbOut;
    logic             pwmbEn;
    logic             ccpOut;
    logic             ccpEn;
    // Per-pin overrides
    logic [PIN_N-1:0] ovrEn;
    logic [PIN_N-1:0] ovrVal;
    // Routed peripheral inputs
    logic             rxdtIn;
    logic             txckIn;
    logic             ssIn;
    logic             t1gIn;
    logic             ccpIn;
    modport top (output altSel, pinDigital, rxdtOut, rxdtOe, txckOut, txckOe, sdoOut, sdoEn,
                 pwmbOut, pwmbEn, ccpOut, ccpEn,
                 input  ovrEn, ovrVal, rxdtIn, txckIn, ssIn, t1gIn, ccpIn);
    modport mux (input  altSel, pinDigital, rxdtOut, rxdtOe, txckOut, txckOe, sdoOut, sdoEn,
                 pwmbOut, pwmbEn, ccpOut, ccpEn,
                 output ovrEn, ovrVal, rxdtIn, txckIn, ssIn, t1gIn, ccpIn);
endinterface : iom_steer_if

// >>> iom_steer_mux.sv
// Steering multiplexer: places peripheral overrides and inputs on the selected pins
`timescale 1ns/1ps
module iom_steer_mux (
    // Carrier
    iom_steer_if.mux st
);
    import iom_pkg::*;

    // One-hot mask of the chosen pin of a two-candidate function
    function automatic logic [PIN_N-1:0] pickMask(input logic choice, input int pin0, input int pin1);
        logic [PIN_N-1:0] m;
        m = '0;
        m[choice ? pin1 : pin0] = 1'b1;
        return m;
    endfunction : pickMask

    logic [PIN_N-1:0] rxdtM;
    logic [PIN_N-1:0] txckM;
    logic [PIN_N-1:0] sdoM;
    logic [PIN_N-1:0] pwmbM;
    logic [PIN_N-1:0] ccpM;
    logic [PIN_N-1:0] ssM;
    logic [PIN_N-1:0] t1gM;

    assign rxdtM = pickMask(st.altSel[SEL_RXDT], RXDT_PIN0, RXDT_PIN1);
    assign txckM = pickMask(st.altSel[SEL_TXCK], TXCK_PIN0, TXCK_PIN1);
    assign sdoM  = pickMask(st.altSel[SEL_SDO],  SDO_PIN0,  SDO_PIN1);
    assign pwmbM = pickMask(st.altSel[SEL_PWMB], PWMB_PIN0, PWMB_PIN1);
    assign ccpM  = pickMask(st.altSel[SEL_CCP],  CCP_PIN0,  CCP_PIN1);
    assign ssM   = pickMask(st.altSel[SEL_SS],   SS_PIN0,   SS_PIN1);
    assign t1gM  = pickMask(st.altSel[SEL_T1G],  T1G_PIN0,  T1G_PIN1);

    // Overrides land only on the chosen pin; lower listed peripheral wins a shared pin
    always_comb begin
        st.ovrEn  = '0;
        st.ovrVal = '0;
        for (int p = PIN_N - 1; p >= 0; p--) begin
            if (pwmbM[p] && st.pwmbEn) begin
                st.ovrEn[p]  = 1'b1;
                st.ovrVal[p] = st.pwmbOut;
            end
            if (ccpM[p] && st.ccpEn) begin
                st.ovrEn[p]  = 1'b1;
                st.ovrVal[p] = st.ccpOut;
            end
            if (sdoM[p] && st.sdoEn) begin
                st.ovrEn[p]  = 1'b1;
                st.ovrVal[p] = st.sdoOut;
            end
            if (rxdtM[p] && st.rxdtOe) begin
                st.ovrEn[p]  = 1'b1;
                st.ovrVal[p] = st.rxdtOut;
            end
            if (txckM[p] && st.txckOe) begin
                st.ovrEn[p]  = 1'b1;
                st.ovrVal[p] = st.txckOut;
            end
        end
    end

    assign st.rxdtIn = |(rxdtM & st.pinDigital);
    assign st.txckIn = |(txckM & st.pinDigital);
    assign st.ssIn   = |(ssM   & st.pinDigital);
    assign st.t1gIn  = |(t1gM  & st.pinDigital);
    assign st.ccpIn  = |(ccpM  & st.pinDigital);
endmodule : iom_steer_mux
